// [pin_ovr_pkg.sv]
// constants for the port f/g/h pin override block
package pin_ovr_pkg;
  // bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  // register byte offsets
  localparam logic [7:0]  OFS_PC_ENABLE = 8'h00;
  localparam logic [7:0]  OFS_IRQ_STS   = 8'h04;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  OFS_PIN_STATE = 8'h0C;
  // word indices of the offsets
  localparam logic [5:0]  IDX_PC_ENABLE = OFS_PC_ENABLE[7:2];
  localparam logic [5:0]  IDX_IRQ_STS   = OFS_IRQ_STS[7:2];
  localparam logic [5:0]  IDX_IRQ_MASK  = OFS_IRQ_MASK[7:2];
  localparam logic [5:0]  IDX_PIN_STATE = OFS_PIN_STATE[7:2];
  // reset values
  localparam logic [7:0]  PC_ENABLE_RST = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RST  = 8'h00;
  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // pin-state register field positions
  localparam int          PS_F_LSB      = 0;
  localparam int          PS_G_LSB      = 8;
  localparam int          PS_H_LSB      = 16;
  localparam int          PS_TPEN_BIT   = 24;
  localparam int          PS_RDIS_BIT   = 25;
  // first-port pin positions
  localparam int          TEST_PORT_LSB = 4;
  localparam int          TEST_CLK_BIT  = 4;
  localparam int          TEST_MODE_BIT = 5;
  localparam int          TEST_DOUT_BIT = 6;
  localparam int          TEST_DIN_BIT  = 7;
  // second-port pin positions
  localparam int          RESET_PIN_BIT = 5;
  localparam int          CNT0_PIN_BIT  = 4;
  localparam int          CNT1_PIN_BIT  = 3;
  // fuse level that means programmed
  localparam logic        FUSE_PROGRAMMED = 1'b0;
  // pin-change source numbers of the third port
  localparam int          PC_SRC_LO     = 16;
  localparam int          PC_SRC_HI     = 23;
endpackage : pin_ovr_pkg

// [port_fgh_alt_function_override.sv]
// pin override logic for ports f, g and h with an axi4-lite register file
// Behaviour
// RULE1 - test fuse forces pull-ups on test inputs
// RULE2 - test fuse takes upper first-port pins away
// RULE3 - test output driven only in shift states
// RULE4 - test output released, pulled high otherwise (during reset the code releases it with its pull-up off)
// RULE5 - test port runs on test clock only
// RULE6 - probe drives serial bits on data input
// RULE7 - probe steers controller via mode select
// RULE8 - software keeps analog pins quiet during conversion
// RULE9 - low first-port pins feed analog channels
// RULE10 - programmed reset fuse: input pin, pull-up on
// RULE11 - second-port bit four feeds counter zero
// RULE12 - second-port bit three feeds counter one
// RULE13 - third-port pins are pin-change sources
// RULE14 - third port is a build-time option
// RULE15 - override enable selects override value
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module port_fgh_alt_function_override #(
  parameter bit HAS_PORT_H = 1'b1
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  // axi4-lite write response
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  // axi4-lite read data
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  // interrupt
  output logic             irq,
  // fuses and test-port controller state
  input  wire logic        test_port_enable_fuse,
  input  wire logic        reset_pin_disable_fuse,
  input  wire logic        instr_shift_state,
  input  wire logic        data_shift_state,
  input  wire logic        test_dout,
  // port register settings
  input  wire logic [7:0]  port_f_reg_out,
  input  wire logic [7:0]  port_f_reg_dir,
  input  wire logic [7:0]  port_f_reg_pullup,
  input  wire logic [5:0]  port_g_reg_out,
  input  wire logic [5:0]  port_g_reg_dir,
  input  wire logic [5:0]  port_g_reg_pullup,
  input  wire logic [7:0]  port_h_reg_out,
  input  wire logic [7:0]  port_h_reg_dir,
  input  wire logic [7:0]  port_h_reg_pullup,
  // pads
  input  wire logic [7:0]  port_f_pad_in,
  output logic [7:0]       port_f_pad_out,
  output logic [7:0]       port_f_pad_oe_n,
  output logic [7:0]       port_f_pullup,
  output logic [7:0]       port_f_in_en,
  input  wire logic [5:0]  port_g_pad_in,
  output logic [5:0]       port_g_pad_out,
  output logic [5:0]       port_g_pad_oe_n,
  output logic [5:0]       port_g_pullup,
  input  wire logic [7:0]  port_h_pad_in,
  output logic [7:0]       port_h_pad_out,
  output logic [7:0]       port_h_pad_oe_n,
  output logic [7:0]       port_h_pullup,
  // alternate function routes
  output logic             test_clk,
  output logic             test_mode,
  output logic             test_din,
  output logic [7:0]       analog_in,
  output logic             counter0_ext_source,
  output logic             counter1_ext_source,
  output logic             ext_reset_n
);

  typedef struct packed {
    logic       fj_s1;
    logic       fj_s2;
    logic       fr_s1;
    logic       fr_s2;
    logic [1:0] sh_s1;
    logic [1:0] sh_s2;
    logic       td_s1;
    logic       td_s2;
    logic [7:0] fpi_s1;
    logic [7:0] fpi_s2;
    logic [5:0] gpi_s1;
    logic [5:0] gpi_s2;
    logic [7:0] hpi_s1;
    logic [7:0] hpi_s2;
    logic [7:0] hpi_prev;
    logic [7:0] pc_en;
    logic [7:0] sts;
    logic [7:0] msk;
    logic       aw_ok;
    logic [5:0] widx;
    logic       w_ok;
    logic [7:0] wdat;
    logic       wbe;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] f_o;
    logic [7:0] f_oe_n;
    logic [7:0] f_pu;
    logic [7:0] f_ie;
    logic [5:0] g_o;
    logic [5:0] g_oe_n;
    logic [5:0] g_pu;
    logic [7:0] h_o;
    logic [7:0] h_oe_n;
    logic [7:0] h_pu;
    logic       cnt0;
    logic       cnt1;
    logic       rst_n;
    logic       irq;
    logic       live;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // pick the override value when its enable is set
  function automatic logic ovr(input logic en, input logic val, input logic dflt);
    ovr = en ? val : dflt;
  endfunction : ovr

  function automatic logic [31:0] rd_mux(input state_s s, input logic [5:0] idx);
    rd_mux = '0;
    case (idx)
      pin_ovr_pkg::IDX_PC_ENABLE: rd_mux[7:0] = s.pc_en;
      pin_ovr_pkg::IDX_IRQ_STS:   rd_mux[7:0] = s.sts;
      pin_ovr_pkg::IDX_IRQ_MASK:  rd_mux[7:0] = s.msk;
      pin_ovr_pkg::IDX_PIN_STATE: begin
        rd_mux[pin_ovr_pkg::PS_F_LSB +: 8] = s.fpi_s2;
        rd_mux[pin_ovr_pkg::PS_G_LSB +: 6] = s.gpi_s2;
        rd_mux[pin_ovr_pkg::PS_H_LSB +: 8] = s.hpi_s2;
        rd_mux[pin_ovr_pkg::PS_TPEN_BIT]   = s.fj_s2;
        rd_mux[pin_ovr_pkg::PS_RDIS_BIT]   = s.fr_s2;
      end
      default: rd_mux = '0;
    endcase
  endfunction : rd_mux

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx <= pin_ovr_pkg::IDX_PIN_STATE);
  endfunction : mapped

  always_comb begin
    logic [7:0] clr;
    logic [7:0] set;
    logic       hi;
    logic       shift;
    clr = '0;
    set = '0;
    hi = 1'b0;
    shift = 1'b0;
    nxt_st = st_ff;
    nxt_st.live = 1'b1;
    // two-flop synchronisers for pins and the test-clock domain
    nxt_st.fj_s1  = test_port_enable_fuse;
    nxt_st.fj_s2  = st_ff.fj_s1;
    nxt_st.fr_s1  = reset_pin_disable_fuse;
    nxt_st.fr_s2  = st_ff.fr_s1;
    nxt_st.sh_s1  = {instr_shift_state, data_shift_state};
    nxt_st.sh_s2  = st_ff.sh_s1;
    nxt_st.td_s1  = test_dout;
    nxt_st.td_s2  = st_ff.td_s1;
    nxt_st.fpi_s1 = port_f_pad_in;
    nxt_st.fpi_s2 = st_ff.fpi_s1;
    nxt_st.gpi_s1 = port_g_pad_in;
    nxt_st.gpi_s2 = st_ff.gpi_s1;
    nxt_st.hpi_s1 = port_h_pad_in;
    nxt_st.hpi_s2 = st_ff.hpi_s1;
    nxt_st.hpi_prev = st_ff.hpi_s2;

    // write channel: address and data taken in either order
    if (s_axil_awvalid && !st_ff.aw_ok) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.widx  = s_axil_awaddr[7:2];
    end
    if (s_axil_wvalid && !st_ff.w_ok) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.wdat = s_axil_wdata[7:0];
      nxt_st.wbe  = s_axil_wstrb[0];
    end
    if (st_ff.bvalid && s_axil_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid) begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = mapped(st_ff.widx) ? pin_ovr_pkg::RESP_OKAY
                                         : pin_ovr_pkg::RESP_SLVERR;
      if (st_ff.wbe) begin
        case (st_ff.widx)
          pin_ovr_pkg::IDX_PC_ENABLE: nxt_st.pc_en = st_ff.wdat;
          pin_ovr_pkg::IDX_IRQ_STS:   clr = st_ff.wdat;
          pin_ovr_pkg::IDX_IRQ_MASK:  nxt_st.msk = st_ff.wdat;
          default: clr = '0;
        endcase
      end
    end

    // read channel: one cycle from address to data
    if (st_ff.rvalid && s_axil_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axil_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_mux(st_ff, s_axil_araddr[7:2]);
      nxt_st.rresp  = mapped(s_axil_araddr[7:2]) ? pin_ovr_pkg::RESP_OKAY
                                                 : pin_ovr_pkg::RESP_SLVERR;
    end

    // pin changes on the third port; a new change beats a clear
    if (HAS_PORT_H) begin // [RULE14]
      set = (st_ff.hpi_s2 ^ st_ff.hpi_prev) & st_ff.pc_en; // [RULE13]
    end
    nxt_st.sts = (st_ff.sts & ~clr) | set;
    nxt_st.irq = |(nxt_st.sts & nxt_st.msk);

    // first port
    shift = |st_ff.sh_s2;
    for (int i = 0; i < 8; i++) begin
      hi = st_ff.fj_s2 && (i >= pin_ovr_pkg::TEST_PORT_LSB); // [RULE2]
      nxt_st.f_pu[i]   = ovr(hi, 1'b1, port_f_reg_pullup[i]); // [RULE1] [RULE15]
      nxt_st.f_oe_n[i] = ~ovr(hi, (i == pin_ovr_pkg::TEST_DOUT_BIT) && shift,
                              port_f_reg_dir[i]); // [RULE3] [RULE4] [RULE15]
      nxt_st.f_o[i]    = ovr(hi && (i == pin_ovr_pkg::TEST_DOUT_BIT), st_ff.td_s2,
                             port_f_reg_out[i]); // [RULE3] [RULE15]
      nxt_st.f_ie[i]   = ovr(hi, 1'b0, 1'b1); // [RULE2] [RULE9]
    end

    // second port
    nxt_st.g_o    = port_g_reg_out; // [RULE11] [RULE12]
    nxt_st.g_oe_n = ~port_g_reg_dir;
    nxt_st.g_pu   = port_g_reg_pullup;
    nxt_st.g_o[pin_ovr_pkg::RESET_PIN_BIT]    = 1'b0; // [RULE10]
    nxt_st.g_oe_n[pin_ovr_pkg::RESET_PIN_BIT] = 1'b1; // [RULE10]
    nxt_st.g_pu[pin_ovr_pkg::RESET_PIN_BIT]   = 1'b1; // [RULE10]
    nxt_st.rst_n = (st_ff.fr_s2 == pin_ovr_pkg::FUSE_PROGRAMMED) ? 1'b1
                 : st_ff.gpi_s2[pin_ovr_pkg::RESET_PIN_BIT]; // [RULE10]
    nxt_st.cnt0 = st_ff.gpi_s2[pin_ovr_pkg::CNT0_PIN_BIT]; // [RULE11]
    nxt_st.cnt1 = st_ff.gpi_s2[pin_ovr_pkg::CNT1_PIN_BIT]; // [RULE12]

    // third port: no overrides, idle when not built
    nxt_st.h_o    = HAS_PORT_H ? port_h_reg_out : 8'h00; // [RULE14]
    nxt_st.h_oe_n = HAS_PORT_H ? ~port_h_reg_dir : 8'hFF;
    nxt_st.h_pu   = HAS_PORT_H ? port_h_reg_pullup : 8'h00;

    // synchronous reset; fuse synchronisers keep running so the
    // test-input pull-ups stay on through reset
    if (!aresetn) begin
      nxt_st        = '0;
      nxt_st.fj_s1  = test_port_enable_fuse;
      nxt_st.fj_s2  = st_ff.fj_s1;
      nxt_st.fr_s1  = reset_pin_disable_fuse;
      nxt_st.fr_s2  = st_ff.fr_s1;
      nxt_st.pc_en  = pin_ovr_pkg::PC_ENABLE_RST;
      nxt_st.msk    = pin_ovr_pkg::IRQ_MASK_RST;
      nxt_st.f_oe_n = 8'hFF;
      nxt_st.g_oe_n = 6'h3F;
      nxt_st.h_oe_n = 8'hFF;
      nxt_st.f_ie   = 8'hFF;
      nxt_st.rst_n  = 1'b1;
      nxt_st.f_pu[pin_ovr_pkg::TEST_DIN_BIT]  = st_ff.fj_s2; // [RULE1]
      nxt_st.f_pu[pin_ovr_pkg::TEST_MODE_BIT] = st_ff.fj_s2; // [RULE1]
      nxt_st.f_pu[pin_ovr_pkg::TEST_CLK_BIT]  = st_ff.fj_s2; // [RULE1]
      nxt_st.g_pu[pin_ovr_pkg::RESET_PIN_BIT] = 1'b1; // [RULE10]
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // outputs
  assign s_axil_awready  = !st_ff.aw_ok;
  assign s_axil_wready   = !st_ff.w_ok;
  assign s_axil_bvalid   = st_ff.bvalid;
  assign s_axil_bresp    = st_ff.bresp;
  assign s_axil_arready  = !st_ff.rvalid;
  assign s_axil_rvalid   = st_ff.rvalid;
  assign s_axil_rdata    = st_ff.rdata;
  assign s_axil_rresp    = st_ff.rresp;
  assign irq             = st_ff.irq;
  assign port_f_pad_out  = st_ff.f_o;
  assign port_f_pad_oe_n = st_ff.f_oe_n;
  assign port_f_pullup   = st_ff.f_pu;
  assign port_f_in_en    = st_ff.f_ie;
  assign port_g_pad_out  = st_ff.g_o;
  assign port_g_pad_oe_n = st_ff.g_oe_n;
  assign port_g_pullup   = st_ff.g_pu;
  assign port_h_pad_out  = st_ff.h_o;
  assign port_h_pad_oe_n = st_ff.h_oe_n;
  assign port_h_pullup   = st_ff.h_pu;
  assign counter0_ext_source = st_ff.cnt0;
  assign counter1_ext_source = st_ff.cnt1;
  assign ext_reset_n     = st_ff.rst_n;
  // raw pad routes into the test-clock domain, never resampled here
  assign test_clk  = port_f_pad_in[pin_ovr_pkg::TEST_CLK_BIT]; // [RULE5]
  assign test_mode = port_f_pad_in[pin_ovr_pkg::TEST_MODE_BIT]; // [RULE7]
  assign test_din  = port_f_pad_in[pin_ovr_pkg::TEST_DIN_BIT]; // [RULE6]
  // analog channels 7..0 straight from the pads
  assign analog_in = port_f_pad_in; // [RULE9]

  default clocking cb @(posedge aclk); endclocking
  // checks skip reset and the first edge that leaves it
  default disable iff (!aresetn || !st_ff.live);

  chk_tap_pullup_forced: assert property ( // [RULE1]
    st_ff.fj_s2 |=> st_ff.f_pu[7] && st_ff.f_pu[5] && st_ff.f_pu[4])
    else $error("test input pull-ups not forced");
  chk_tap_pins_taken: assert property ( // [RULE2]
    st_ff.fj_s2 |=> (st_ff.f_ie[7:4] == 4'h0) && st_ff.f_oe_n[7]
                    && st_ff.f_oe_n[5] && st_ff.f_oe_n[4])
    else $error("upper first-port pins not taken over");
  chk_tdo_drive: assert property ( // [RULE3]
    st_ff.fj_s2 && (st_ff.sh_s2 != 2'b00)
    |=> !st_ff.f_oe_n[6] && (st_ff.f_o[6] == $past(st_ff.td_s2)))
    else $error("test output not driven in shift state");
  chk_tdo_release: assert property ( // [RULE4]
    st_ff.fj_s2 && (st_ff.sh_s2 == 2'b00) |=> st_ff.f_oe_n[6] && st_ff.f_pu[6])
    else $error("test output driven outside shift");
  chk_override_dir: assert property ( // [RULE15]
    !st_ff.fj_s2 |=> st_ff.f_oe_n == ~$past(port_f_reg_dir))
    else $error("direction not from port register");
  chk_analog_low: assert property ( // [RULE9]
    1'b1 |=> (st_ff.f_o[3:0] == $past(port_f_reg_out[3:0])) && (st_ff.f_ie[3:0] == 4'hF))
    else $error("override on analog pins");
  chk_reset_pin_io: assert property ( // [RULE10]
    st_ff.fr_s2 == pin_ovr_pkg::FUSE_PROGRAMMED
    |=> st_ff.g_pu[5] && st_ff.g_oe_n[5] && st_ff.rst_n)
    else $error("reset pin not plain input");
  chk_counter0_src: assert property ( // [RULE11]
    ##1 st_ff.cnt0 == $past(st_ff.gpi_s2[4]))
    else $error("counter0 source wrong");
  chk_counter1_src: assert property ( // [RULE12]
    ##1 st_ff.cnt1 == $past(st_ff.gpi_s2[3]))
    else $error("counter1 source wrong");
  chk_pc_sets_flag: assert property ( // [RULE13]
    HAS_PORT_H && ((st_ff.hpi_s2 ^ st_ff.hpi_prev) & st_ff.pc_en) != 8'h00
    |=> (st_ff.sts & $past((st_ff.hpi_s2 ^ st_ff.hpi_prev) & st_ff.pc_en))
        == $past((st_ff.hpi_s2 ^ st_ff.hpi_prev) & st_ff.pc_en))
    else $error("pin change not flagged");

  cov_tdo_shift: cover property (st_ff.fj_s2 && !st_ff.f_oe_n[6]);
  cov_pc_irq:    cover property ($rose(irq));
  cov_rst_io:    cover property (st_ff.fr_s2 == pin_ovr_pkg::FUSE_PROGRAMMED);

endmodule : port_fgh_alt_function_override

// [test_probe_model.sv]
// behavioural test probe driving the test clock, mode and data pins
`timescale 1ns/1ps
module test_probe_model (
  // clock of the bench
  input  wire logic aclk,
  input  wire logic run,
  // probe pins
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  logic [7:0] pat_ff;
  // test clock only toggles while a session runs, stands low between
  always @(posedge aclk) begin
    if (run) begin
      tck <= ~tck;
      if (tck) begin
        tdi    <= pat_ff[0];
        tms    <= pat_ff[7];
        pat_ff <= {pat_ff[6:0], pat_ff[7]};
      end
    end else begin
      tck <= 1'b0;
      pat_ff <= 8'hB4;
      // released lines sit at the forced pull-up level
      tms <= 1'b1;
      tdi <= 1'b1;
    end
  end
endmodule : test_probe_model

// [test_port_fgh_alt_function_override.sv]
// self-checking bench for the port f/g/h override block
`timescale 1ns/1ps
module test_port_fgh_alt_function_override;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, tpen, rdis, ishift, dshift, tdout;
  logic [7:0]  awaddr, araddr, f_out, f_dir, f_pu, h_out, h_dir, h_pu, h_pin;
  logic [7:0]  f_pad, f_po, f_oe_n, f_pull, f_ien, h_po, h_oe_n, h_pull, ain;
  logic [5:0]  g_out, g_dir, g_pu, g_pin, g_po, g_oe_n, g_pull;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        tck, tms, tdi, run, t_clk, t_mode, t_din, c0, c1, ext_rst_n;
  int          n_mismatch, n_checks;

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // board level: released test output pin is pulled high
  assign f_pad = {tdi, (f_oe_n[6] ? 1'b1 : f_po[6]), tms, tck, 4'h9};

  test_probe_model probe (.aclk(aclk), .run(run), .tck(tck), .tms(tms), .tdi(tdi));

  port_fgh_alt_function_override dut (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .irq(irq),
    .test_port_enable_fuse(tpen), .reset_pin_disable_fuse(rdis),
    .instr_shift_state(ishift), .data_shift_state(dshift), .test_dout(tdout),
    .port_f_reg_out(f_out), .port_f_reg_dir(f_dir), .port_f_reg_pullup(f_pu),
    .port_g_reg_out(g_out), .port_g_reg_dir(g_dir), .port_g_reg_pullup(g_pu),
    .port_h_reg_out(h_out), .port_h_reg_dir(h_dir), .port_h_reg_pullup(h_pu),
    .port_f_pad_in(f_pad), .port_f_pad_out(f_po), .port_f_pad_oe_n(f_oe_n),
    .port_f_pullup(f_pull), .port_f_in_en(f_ien), .port_g_pad_in(g_pin),
    .port_g_pad_out(g_po), .port_g_pad_oe_n(g_oe_n), .port_g_pullup(g_pull),
    .port_h_pad_in(h_pin), .port_h_pad_out(h_po), .port_h_pad_oe_n(h_oe_n),
    .port_h_pullup(h_pull), .test_clk(t_clk), .test_mode(t_mode), .test_din(t_din),
    .analog_in(ain), .counter0_ext_source(c0), .counter1_ext_source(c1),
    .ext_reset_n(ext_rst_n)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, dd;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ad = 0;
    dd = 0;
    do begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // pin paths settle within three edges
  task automatic settle();
    repeat (5) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    test_done();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ishift, dshift, tdout, tpen} = '0;
    {awaddr, araddr, wdata, wstrb, run} = '0;
    rdis  = 1'b0;
    f_out = 8'hA5; // held still, never switched under a conversion
    f_dir = 8'hFF;
    f_pu  = 8'h3C;
    g_out = 6'h3F;
    g_dir = 6'h3F;
    g_pu  = 6'h00;
    g_pin = 6'h10;
    h_out = 8'h5A;
    h_dir = 8'h0F;
    h_pu  = 8'hC3;
    h_pin = 8'h00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(pin_ovr_pkg::OFS_PC_ENABLE, rd, rs);
    chk("pc_enable reset", 32'h0, rd);
    chk("pc_enable resp", {30'h0, pin_ovr_pkg::RESP_OKAY}, {30'h0, rs});
    rd_reg(pin_ovr_pkg::OFS_IRQ_MASK, rd, rs);
    chk("irq_mask reset", 32'h0, rd);
    rd_reg(8'h10, rd, rs);
    chk("unmapped read resp", {30'h0, pin_ovr_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(8'h10, 32'hFF, rs);
    chk("unmapped write resp", {30'h0, pin_ovr_pkg::RESP_SLVERR}, {30'h0, rs});
    settle();
    // fuse off: registers reach all first-port pins
    chk("f oe_n free", {24'h0, ~f_dir}, {24'h0, f_oe_n});
    chk("f out free", {24'h0, f_out}, {24'h0, f_po});
    chk("f pull free", {24'h0, f_pu}, {24'h0, f_pull});
    chk("analog in", {24'h0, f_pad}, {24'h0, ain});
    // reset fuse programmed: input only, pull-up on
    chk("g5 pullup", 32'h1, {31'h0, g_pull[5]});
    chk("g5 oe_n", 32'h1, {31'h0, g_oe_n[5]});
    chk("ext reset", 32'h1, {31'h0, ext_rst_n});
    chk("g out", 32'h1F, {26'h0, g_po});
    chk("g pullups", 32'h20, {26'h0, g_pull});
    chk("g cnt oe_n", 32'h0, {30'h0, g_oe_n[4:3]});
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      g_pin <= i ? 6'h08 : 6'h10;
      settle();
      chk("counter0 src", {31'h0, i == 0}, {31'h0, c0});
      chk("counter1 src", {31'h0, i == 1}, {31'h0, c1});
    end
    // reset fuse left unprogrammed: the pad is the reset input
    @(posedge aclk);
    rdis <= 1'b1;
    settle();
    chk("ext reset pad low", 32'h0, {31'h0, ext_rst_n});
    @(posedge aclk);
    g_pin <= 6'h28;
    settle();
    chk("ext reset pad high", 32'h1, {31'h0, ext_rst_n});
    // test port on, no shift: pins taken and test output released
    @(posedge aclk);
    tpen <= 1'b1;
    run  <= 1'b1;
    rdis <= 1'b0;
    settle();
    chk("f pullups", 32'hFC, {24'h0, f_pull});
    chk("f in_en", 32'h0F, {24'h0, f_ien});
    chk("f oe_n", 32'hF0, {24'h0, f_oe_n});
    chk("f out low", 32'h5, {28'h0, f_po[3:0]});
    for (int i = 0; i < 6; i++) begin
      @(negedge aclk);
      chk("test pins", {29'h0, f_pad[7], f_pad[5], f_pad[4]}, {29'h0, t_din, t_mode, t_clk});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      dshift <= i[0];
      ishift <= i[1];
      tdout  <= i[0] ^ i[1];
      settle();
      chk("tdo oe_n", {31'h0, i == 0}, {31'h0, f_oe_n[6]});
      if (i != 0) chk("tdo value", {31'h0, i[0] ^ i[1]}, {31'h0, f_po[6]});
    end
    @(posedge aclk);
    run <= 1'b0;
    rd_reg(pin_ovr_pkg::OFS_PIN_STATE, rd, rs);
    chk("pin state", {6'h0, rdis, tpen, 24'h0}, {6'h0, rd[25:24], 24'h0});
    chk("pin state g", {26'h0, g_pin}, {26'h0, rd[13:8]});
    // pin changes on the third port
    chk("h oe_n", {24'h0, ~h_dir}, {24'h0, h_oe_n});
    chk("h out", {24'h0, h_out}, {24'h0, h_po});
    chk("h pullups", {24'h0, h_pu}, {24'h0, h_pull});
    wr(pin_ovr_pkg::OFS_PC_ENABLE, 32'h81, rs);
    chk("pc_enable write resp", {30'h0, pin_ovr_pkg::RESP_OKAY}, {30'h0, rs});
    wr(pin_ovr_pkg::OFS_IRQ_MASK, 32'h01, rs);
    @(posedge aclk);
    h_pin <= 8'h83;
    settle();
    rd_reg(pin_ovr_pkg::OFS_IRQ_STS, rd, rs);
    chk("irq status", 32'h81, rd);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(pin_ovr_pkg::OFS_IRQ_STS, 32'h01, rs);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(pin_ovr_pkg::OFS_IRQ_MASK, 32'h80, rs);
    settle();
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(pin_ovr_pkg::OFS_IRQ_STS, 32'h80, rs);
    rd_reg(pin_ovr_pkg::OFS_IRQ_STS, rd, rs);
    chk("irq status clr", 32'h0, rd);
    settle();
    chk("irq low", 32'h0, {31'h0, irq});
    // reset in mid-run with the test port on: its test-input pull-ups must hold
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("reset pullups", 32'hB0, {24'h0, f_pull});
    chk("reset oe_n", 32'hFF, {24'h0, f_oe_n});
    chk("reset g5 pullup", 32'h1, {31'h0, g_pull[5]});
    @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk("pullups after reset", 32'hFC, {24'h0, f_pull});
    rd_reg(pin_ovr_pkg::OFS_IRQ_MASK, rd, rs);
    chk("irq_mask after reset", 32'h0, rd);
    test_done();
  end
endmodule : test_port_fgh_alt_function_override
